// ---- board_model.sv ----
// Board model: pin levels seen by the block's receivers
`timescale 1ns/10ps
`default_nettype none
module board_model (
  // Clock
  input wire logic                  clk_sys,
  // Pad controls from the block
  input wire port_io_pkg::pad_ctl_t pad_ctl,
  // External drivers set by the bench
  input wire logic [39:0]           ext_drive,
  input wire logic [39:0]           ext_level,
  // Pin levels
  output logic [39:0]               pad_in
);
  logic [39:0] churn = '0;
  // Floating pins toggle so a stale level never passes for data
  always_ff @(posedge clk_sys) churn <= ~churn;
  // Own driver wins, then board driver, then weak pull-up
  always_comb pad_in = (pad_ctl.drive_en & pad_ctl.level) |
    (~pad_ctl.drive_en & ext_drive & ext_level) |
    (~pad_ctl.drive_en & ~ext_drive & pad_ctl.pullup_en) |
    (~pad_ctl.drive_en & ~ext_drive & ~pad_ctl.pullup_en & churn);
endmodule : board_model
`default_nettype wire

// ---- pio_asserts.sv ----
// Checker for the port I/O block, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module pio_asserts #(
  parameter bit WIDE_PACKAGE = 1'b1
) (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     reset_n,
  // Register port
  input wire port_io_pkg::sfr_req_t    sfr_req,
  input wire logic [7:0]               sfr_rdata,
  // Crossbar side
  input wire port_io_pkg::periph_req_t periph_req,
  input wire logic [31:0]              crossbar_skip,
  input wire logic [7:0]               crossbar_assign_a,
  input wire logic [7:0]               crossbar_assign_b,
  // Pads
  input wire logic [39:0]              pad_in,
  input wire port_io_pkg::pad_ctl_t    pad_ctl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Port 4 is left out: it never waits for the crossbar
  localparam logic [39:0] MGD   = 40'h00FFFFFFFF;
  localparam logic [7:0]  P3_ON = WIDE_PACKAGE ? 8'hFF : 8'h01;
  //////////////////////////////////////////////////////////////////
  AST_ANALOG_QUIET: assert property (
    (~pad_ctl.receiver_en & (pad_ctl.drive_en | pad_ctl.pullup_en)) == '0)
    else $error("analog pin not quiet");
  AST_RESET_DIGITAL: assert property (
    $rose(reset_n) |=> pad_ctl.receiver_en == {8'hFF, P3_ON, 24'hFFFFFF})
    else $error("pins not digital after reset");
  AST_XBAR_GATE: assert property (
    !$past(crossbar_assign_b[6]) |-> (pad_ctl.drive_en & MGD) == '0)
    else $error("managed port drives with crossbar off");
  AST_PULLUP_LOW: assert property (
    (pad_ctl.pullup_en & pad_ctl.drive_en & ~pad_ctl.level) == '0)
    else $error("pull-up on while driving low");
  AST_PULLUP_DISABLE: assert property (
    $past(crossbar_assign_b[7]) |-> pad_ctl.pullup_en == '0)
    else $error("pull-up on while disabled");
  AST_LATCH_READ: assert property (
    sfr_req.rd && sfr_req.addr == 8'hB0 |=>
      sfr_rdata == ($past(pad_in[31:24]) & pad_ctl.receiver_en[31:24]))
    else $error("latch read not masked pin level");
  AST_SMBUS_OD: assert property (
    crossbar_assign_b[6] |=> (pad_ctl.drive_en & pad_ctl.level & MGD &
      $past(periph_req.claim) & $past(periph_req.smbus)) == '0)
    else $error("two-wire pin driven high");
  AST_CLAIM_LEVEL: assert property (
    crossbar_assign_b[6] |=> ((pad_ctl.level ^ $past(periph_req.level)) &
      $past(periph_req.claim) & MGD) == '0)
    else $error("claimed pin level wrong");
  // Main scenarios reached
  cover property (sfr_req.rd && sfr_req.addr == 8'hB0);
  cover property ($rose(crossbar_assign_b[6]));
  cover property (crossbar_assign_b[6] && periph_req.smbus != '0);
endmodule : pio_asserts
bind port_io_crossbar_config pio_asserts #(.WIDE_PACKAGE(WIDE_PACKAGE))
  u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .periph_req(periph_req),
  .crossbar_skip(crossbar_skip), .crossbar_assign_a(crossbar_assign_a),
  .crossbar_assign_b(crossbar_assign_b), .pad_in(pad_in),
  .pad_ctl(pad_ctl));
`default_nettype wire

// ---- port_io_crossbar_config.sv ----
// Port I/O pad control with crossbar gate and special-function registers
//
// Function
// - A pin in analog input mode has pull-up, output driver and digital receiver all off.
// - An input type select bit of one means digital input and zero means analog input.
// - Reset leaves every pin in digital input mode.
// - Each driver is open-drain or push-pull by its driver type bit, even for peripheral signals other than the two-wire bus.
// - Pins carrying the two-wire bus data and clock always drive open-drain.
// - With the global pull-up disable bit low every open-drain pin gets a weak pull-up, push-pull never.
// - The weak pull-up is off while the pin actively drives a zero.
// - The crossbar enable bit activates peripheral assignment; before that managed pins are inputs.
// - While the crossbar is off the four managed ports cannot drive at all.
// - The fifth port is plain general-purpose I/O regardless of the crossbar.
// - A latch one drives high and zero low, but a one floats when the pin is open-drain.
// - Reading a latch gives zero for analog pins and the live pin level otherwise.
// - Port three has pins one to seven only on the larger package, otherwise only pin zero.
`timescale 1ns/10ps
`default_nettype none

module port_io_crossbar_config #(
  parameter bit WIDE_PACKAGE = 1'b1
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // Special-function register port
  input  wire port_io_pkg::sfr_req_t    sfr_req,
  output logic [7:0]                    sfr_rdata,
  // Crossbar decode side
  input  wire port_io_pkg::periph_req_t periph_req,
  output logic [port_io_pkg::XBAR_PORTS*8-1:0] crossbar_skip,
  output logic [7:0]                    crossbar_assign_a,
  output logic [7:0]                    crossbar_assign_b,
  // Pads
  input  wire logic [port_io_pkg::NUM_PINS-1:0] pad_in,
  output port_io_pkg::pad_ctl_t         pad_ctl
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [port_io_pkg::NUM_PORTS-1:0][7:0]  latch;
    logic [port_io_pkg::NUM_PORTS-1:0][7:0]  in_type;
    logic [port_io_pkg::NUM_PORTS-1:0][7:0]  drv_type;
    logic [port_io_pkg::XBAR_PORTS-1:0][7:0] skip;
    logic [7:0]                              assign_a;
    logic [7:0]                              assign_b;
    logic [7:0]                              rdata;
    port_io_pkg::pad_ctl_t                   pads;
  } state_t;

  // Whole block state; pads registered to keep outputs on flops
  state_t state;
  state_t next_state;

  // Helper nets for the pad equations
  logic                             xbar_en;
  logic                             pullup_off;
  logic [port_io_pkg::NUM_PINS-1:0] present;
  logic [port_io_pkg::NUM_PINS-1:0] digital;
  logic [port_io_pkg::NUM_PINS-1:0] read_level;
  port_io_pkg::pad_ctl_t            pad_calc;

  // Gate and global pull-up disable bits
  assign xbar_en    = state.assign_b[port_io_pkg::CROSSBAR_ENABLE_POS];
  assign pullup_off = state.assign_b[port_io_pkg::GLOBAL_PULLUP_DISABLE_POS];

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin pad control

  // Each pin is worked out from its own register bits and crossbar request
  // Pin i sits at port i/8, bit i%8
  generate
    for (genvar i = 0; i < port_io_pkg::NUM_PINS; i++) begin : g_pin
      localparam int PORT = i / 8;
      localparam int BIT  = i % 8;
      localparam bit MANAGED = (PORT < port_io_pkg::XBAR_PORTS);
      localparam bit STUB =
        (PORT == port_io_pkg::STUB_PORT) && (BIT >= port_io_pkg::STUB_KEEP);
      // Per-pin intermediate terms
      logic active;
      logic claimed;
      logic value;
      logic open_drain;
      logic drive;

      // Missing pins of the small package are dead pads
      assign present[i] = WIDE_PACKAGE || !STUB;
      assign digital[i] = state.in_type[PORT][BIT] && present[i];

      // Managed ports wait for the crossbar; the fifth port never does
      assign active  = MANAGED ? xbar_en : 1'b1;
      assign claimed = MANAGED && xbar_en && periph_req.claim[i];

      // Unclaimed pins fall back to the latch value
      assign value   = claimed ? periph_req.level[i]
                               : state.latch[PORT][BIT];

      // No automatic type choice, except the two-wire bus pins
      assign open_drain = (claimed && periph_req.smbus[i])
                          || !state.drv_type[PORT][BIT];

      // Open-drain only pulls low; a one floats
      assign drive = digital[i] && active
                     && (!open_drain || !value);
      assign pad_calc.level[i]       = value;
      assign pad_calc.drive_en[i]    = drive;

      // Pull-up only on open-drain, never while pulling low
      assign pad_calc.pullup_en[i]   = digital[i] && open_drain
                                       && !pullup_off
                                       && !drive;
      assign pad_calc.receiver_en[i] = digital[i];

      // Analog pins read as zero so a floating receiver never leaks in
      assign read_level[i] = digital[i] && pad_in[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and reads

  // Address decode; reads answer one cycle after the strobe
  // A write and a read of one address in one cycle return the old value
  always_comb begin
    next_state       = state;
    next_state.pads  = pad_calc;
    next_state.rdata = port_io_pkg::UNMAPPED_READ;
    for (int p = 0; p < port_io_pkg::NUM_PORTS; p++) begin
      // Port latch write
      if (sfr_req.wr && sfr_req.addr == port_io_pkg::LATCH_ADDR[p]) begin
        next_state.latch[p] = sfr_req.wdata;
      end
      // Input type write
      if (sfr_req.wr && sfr_req.addr == port_io_pkg::INTYPE_ADDR[p]) begin
        next_state.in_type[p] = sfr_req.wdata;
      end
      // Driver type write
      if (sfr_req.wr && sfr_req.addr == port_io_pkg::DRVTYPE_ADDR[p]) begin
        next_state.drv_type[p] = sfr_req.wdata;
      end

      // Latch read shows the masked pin, not the stored latch
      if (sfr_req.rd && sfr_req.addr == port_io_pkg::LATCH_ADDR[p]) begin
        next_state.rdata = read_level[p*8 +: 8];
      end
      // Input type read
      if (sfr_req.rd && sfr_req.addr == port_io_pkg::INTYPE_ADDR[p]) begin
        next_state.rdata = state.in_type[p];
      end
      // Driver type read
      if (sfr_req.rd && sfr_req.addr == port_io_pkg::DRVTYPE_ADDR[p]) begin
        next_state.rdata = state.drv_type[p];
      end
    end

    for (int p = 0; p < port_io_pkg::XBAR_PORTS; p++) begin
      // Skip write; these bits only steer the outside priority decode
      if (sfr_req.wr && sfr_req.addr == port_io_pkg::SKIP_ADDR[p]) begin
        next_state.skip[p] = sfr_req.wdata;
      end

      // Skip read
      if (sfr_req.rd && sfr_req.addr == port_io_pkg::SKIP_ADDR[p]) begin
        next_state.rdata = state.skip[p];
      end
    end

    // Assignment register A write
    if (sfr_req.wr && sfr_req.addr == port_io_pkg::ASSIGN_A_ADDR) begin
      next_state.assign_a = sfr_req.wdata;
    end
    // Crossbar enable and pull-up disable live here
    if (sfr_req.wr && sfr_req.addr == port_io_pkg::ASSIGN_B_ADDR) begin
      next_state.assign_b = sfr_req.wdata;
    end

    // Assignment register reads
    if (sfr_req.rd && sfr_req.addr == port_io_pkg::ASSIGN_A_ADDR) begin
      next_state.rdata = state.assign_a;
    end
    if (sfr_req.rd && sfr_req.addr == port_io_pkg::ASSIGN_B_ADDR) begin
      next_state.rdata = state.assign_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Reset: all digital inputs, latches high, crossbar off, pads quiet
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int p = 0; p < port_io_pkg::NUM_PORTS; p++) begin
        state.latch[p]    <= port_io_pkg::LATCH_RESET;
        state.in_type[p]  <= port_io_pkg::INTYPE_RESET;
        state.drv_type[p] <= port_io_pkg::DRVTYPE_RESET;
      end
      // Skip registers
      for (int p = 0; p < port_io_pkg::XBAR_PORTS; p++) begin
        state.skip[p] <= port_io_pkg::SKIP_RESET;
      end
      // Assignment registers: crossbar off, pull-ups allowed
      state.assign_a <= port_io_pkg::ASSIGN_RESET;
      state.assign_b <= port_io_pkg::ASSIGN_RESET;
      state.rdata    <= port_io_pkg::UNMAPPED_READ;
      state.pads     <= '0;
    end else begin
      // Everything else follows the decode
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata         = state.rdata;
  assign crossbar_skip     = state.skip;
  assign crossbar_assign_a = state.assign_a;
  assign crossbar_assign_b = state.assign_b;
  assign pad_ctl           = state.pads;

endmodule : port_io_crossbar_config

`default_nettype wire

// ---- port_io_pkg.sv ----
// Shared constants and types for the port I/O crossbar configuration block
package port_io_pkg;

  // Port geometry
  localparam int NUM_PORTS    = 5;
  localparam int XBAR_PORTS   = 4;
  localparam int PORT_BITS    = 8;
  localparam int NUM_PINS     = NUM_PORTS * PORT_BITS;
  localparam int STUB_PORT    = 3;
  localparam int STUB_KEEP    = 1;

  // Special-function register addresses, index is the port number
  localparam logic [7:0] LATCH_ADDR [NUM_PORTS] =
    '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hC7};
  localparam logic [7:0] INTYPE_ADDR [NUM_PORTS] =
    '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5};
  localparam logic [7:0] DRVTYPE_ADDR [NUM_PORTS] =
    '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAE};
  localparam logic [7:0] SKIP_ADDR [XBAR_PORTS] =
    '{8'hD4, 8'hD5, 8'hD6, 8'hDF};
  localparam logic [7:0] ASSIGN_A_ADDR = 8'hE1;
  localparam logic [7:0] ASSIGN_B_ADDR = 8'hE2;

  // Field positions inside crossbar_assign_b
  localparam int GLOBAL_PULLUP_DISABLE_POS = 7;
  localparam int CROSSBAR_ENABLE_POS       = 6;

  // Reset values
  localparam logic [7:0] LATCH_RESET    = 8'hFF;
  localparam logic [7:0] INTYPE_RESET   = 8'hFF;
  localparam logic [7:0] DRVTYPE_RESET  = 8'h00;
  localparam logic [7:0] SKIP_RESET     = 8'h00;
  localparam logic [7:0] ASSIGN_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Pad controls, one bit per pin, pin n of port p at p*8+n
  typedef struct packed {
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] drive_en;
    logic [NUM_PINS-1:0] pullup_en;
    logic [NUM_PINS-1:0] receiver_en;
  } pad_ctl_t;

  // Requests from the crossbar priority decode, one bit per pin
  typedef struct packed {
    logic [NUM_PINS-1:0] claim;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] smbus;
  } periph_req_t;

  // Register-port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage : port_io_pkg

// ---- tb_top.sv ----
// Testbench for the port I/O crossbar configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic                     clk_sys    = 1'b0;
  logic                     reset_n    = 1'b0;
  port_io_pkg::sfr_req_t    sfr_req    = '0;
  port_io_pkg::periph_req_t periph_req = '0;
  port_io_pkg::pad_ctl_t    pad_ctl;
  logic [7:0]               sfr_rdata;
  logic [31:0]              crossbar_skip;
  logic [7:0]               crossbar_assign_a;
  logic [7:0]               crossbar_assign_b;
  port_io_pkg::pad_ctl_t    pad_ctl_small;
  logic [39:0]              pad_in;
  logic [39:0]              ext_drive  = '0;
  logic [39:0]              ext_level  = '0;
  int                       bad_count  = 0;
  int                       cmp_count  = 0;
  port_io_crossbar_config u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .periph_req(periph_req),
    .crossbar_skip(crossbar_skip), .crossbar_assign_a(crossbar_assign_a),
    .crossbar_assign_b(crossbar_assign_b), .pad_in(pad_in),
    .pad_ctl(pad_ctl));
  board_model u_board (.clk_sys(clk_sys), .pad_ctl(pad_ctl),
    .ext_drive(ext_drive), .ext_level(ext_level), .pad_in(pad_in));
  // Small package variant shares every input
  port_io_crossbar_config #(.WIDE_PACKAGE(1'b0)) u_dut_small (
    .clk_sys(clk_sys), .reset_n(reset_n), .sfr_req(sfr_req),
    .sfr_rdata(), .periph_req(periph_req), .crossbar_skip(),
    .crossbar_assign_a(), .crossbar_assign_b(), .pad_in(pad_in),
    .pad_ctl(pad_ctl_small));
  //////////////////////////////////////////////////////////////////
  // Register writes idle one cycle so strobes never rise twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    sfr_req = '0;
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    sfr_req = '0;
    `CHK(sfr_rdata, e)
    @(negedge clk_sys);
  endtask : rd
  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(pad_ctl.receiver_en, {40{1'b1}})
    `CHK(pad_ctl.pullup_en, {40{1'b1}})
    `CHK(pad_ctl.drive_en, 40'h0000000000)
    `CHK(pad_ctl_small.receiver_en[31:24], 8'h01)
    rd(8'hB0, 8'hFF);
    rd(8'hF4, 8'hFF);
    rd(8'h00, 8'h00);
  endtask : t_reset
  task automatic t_analog();
    ext_drive = 40'h00FF000000;
    ext_level = 40'h003C000000;
    wr(8'hF4, 8'h0F);
    `CHK(pad_ctl.receiver_en[31:24], 8'h0F)
    `CHK(pad_ctl.pullup_en[31:24], 8'h0F)
    rd(8'hB0, 8'h0C);
    wr(8'hDF, 8'hF0);
    `CHK(crossbar_skip[31:24], 8'hF0)
  endtask : t_analog
  task automatic t_gate();
    wr(8'hA4, 8'hFF);
    periph_req.claim = 40'h00000000FF;
    wr(8'h80, 8'h55);
    `CHK(pad_ctl.drive_en[7:0], 8'h00)
    `CHK(pad_ctl.level[7:0], 8'h55)
    periph_req.claim = '0;
    wr(8'hAE, 8'hFF);
    wr(8'hC7, 8'hA5);
    `CHK(pad_ctl.drive_en[39:32], 8'hFF)
    `CHK(pad_ctl.level[39:32], 8'hA5)
    wr(8'hE1, 8'h5A);
    `CHK(crossbar_assign_a, 8'h5A)
    wr(8'hE2, 8'h40);
    `CHK(crossbar_assign_b, 8'h40)
    rd(8'hE2, 8'h40);
    rd(8'hA4, 8'hFF);
    `CHK(pad_ctl.drive_en[7:0], 8'hFF)
    `CHK(pad_ctl.level[7:0], 8'h55)
    `CHK(pad_ctl.pullup_en[7:0], 8'h00)
    wr(8'hA4, 8'h00);
    `CHK(pad_ctl.drive_en[7:0], 8'hAA)
    `CHK(pad_ctl.pullup_en[7:0], 8'h55)
    rd(8'h80, 8'h55);
    wr(8'hE2, 8'hC0);
    `CHK(pad_ctl.pullup_en, 40'h0000000000)
  endtask : t_gate
  task automatic t_claim();
    periph_req = '{40'h000000FF00, 40'h000000FF00, 40'h0000000300};
    wr(8'hA5, 8'hFF);
    `CHK(pad_ctl.drive_en[15:8], 8'hFC)
    periph_req.level = '0;
    repeat (2) @(negedge clk_sys);
    `CHK(pad_ctl.drive_en[15:8], 8'hFF)
    `CHK(pad_ctl.level[15:8], 8'h00)
  endtask : t_claim
  //////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_reset();
    t_analog();
    t_gate();
    t_claim();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
